// ### shared/tcf_cfg.svh
// Purpose: constants of the table cam follower
// Assumes: 32-bit register port with byte addresses
// Notes: arrays of per-axis registers step by one word per axis
`ifndef TCF_CFG_SVH
`define TCF_CFG_SVH
`define TCF_AXES 8
`define TCF_PW 32
`define TCF_MW 23
`define TCF_IW 9
`define TCF_LAST_IDX 9'h100
`define TCF_A_CTRL 8'h00
`define TCF_A_MCYC 8'h04
`define TCF_A_IVL 8'h08
`define TCF_A_START 8'h0C
`define TCF_A_CNT 8'h10
`define TCF_A_TSEL 8'h14
`define TCF_A_TDAT 8'h18
`define TCF_A_STAT 8'h1C
`define TCF_A_SCYC 8'h20
`define TCF_A_ENG 8'h40
`define TCF_A_DIS 8'h60
`define TCF_A_MPOS 8'h80
`define TCF_CTRL_EN 0
`define TCF_SEL_LSB 4
`define TCF_STAT_DIS_LSB 8
`define TCF_RST_IVL 23'h000001
`endif

// ### shared/tcf_pkg.sv
// Purpose: types of the table cam follower
// Assumes: nothing beyond the constants header
// Notes: imported nowhere, always scoped
package tcf_pkg;
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_RDA, SQ_RDB, SQ_ST, SQ_RUN
  } tcf_seq_t;
endpackage : tcf_pkg

// ### rtl/tcf_interp.sv
// Purpose: linear interpolation between two cam table points
// Assumes: interval width nonzero, offset below it
// Notes: serial divider, one quotient bit per enabled cycle
`timescale 1ns/100ps
`default_nettype none
module tcf_interp #(
  parameter int PW = 32,
  parameter int MW = 23
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic start_i,
  input wire logic [PW-1:0] a_i,
  input wire logic [PW-1:0] b_i,
  input wire logic [MW-1:0] off_i,
  input wire logic [MW-1:0] ivl_i,
  output logic done_o,
  output logic [PW-1:0] y_o
);
  localparam int DW = PW + MW + 2;
  localparam int CW = $clog2(DW + 1);
  if (MW >= PW) begin : g_chk
    $error("tcf_interp: MW must be below PW");
  end
  logic busy, next_busy, next_done, neg, next_neg;
  logic [CW-1:0] cnt, next_cnt;
  logic [DW-1:0] num, next_num, quo, next_quo;
  logic [MW-1:0] rem, next_rem;
  logic [PW-1:0] base, next_base, next_y;

  always_comb begin
    logic [MW:0] trial;
    logic [DW-1:0] q1;
    logic signed [DW-1:0] prod;
    logic signed [DW-1:0] sq;
    trial = '0;
    q1 = '0;
    prod = '0;
    sq = '0;
    next_busy = busy;
    next_cnt = cnt;
    next_num = num;
    next_rem = rem;
    next_quo = quo;
    next_neg = neg;
    next_base = base;
    next_y = y_o;
    next_done = 1'b0;
    if (start_i && !busy) begin
      // (b - a) * offset, later divided by the interval
      prod = $signed({b_i[PW-1], b_i}) - $signed({a_i[PW-1], a_i});
      prod = prod * $signed({1'b0, off_i});
      next_neg = prod[DW-1];
      next_num = prod[DW-1] ? DW'(-prod) : prod;
      next_rem = '0;
      next_quo = '0;
      next_base = a_i;
      next_cnt = CW'(DW);
      next_busy = 1'b1;
    end else if (busy) begin
      trial = {rem, num[DW-1]};
      next_num = num << 1;
      if (trial >= {1'b0, ivl_i}) begin
        next_rem = MW'(trial - {1'b0, ivl_i});
        q1 = {quo[DW-2:0], 1'b1};
      end else begin
        next_rem = trial[MW-1:0];
        q1 = {quo[DW-2:0], 1'b0};
      end
      next_quo = q1;
      next_cnt = cnt - CW'(1);
      if (cnt == CW'(1)) begin
        sq = neg ? -$signed(q1) : $signed(q1);
        next_y = base + sq[PW-1:0];
        next_done = 1'b1;
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy <= 1'b0;
      cnt <= '0;
      num <= '0;
      rem <= '0;
      quo <= '0;
      neg <= 1'b0;
      base <= '0;
      y_o <= '0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      busy <= next_busy;
      cnt <= next_cnt;
      num <= next_num;
      rem <= next_rem;
      quo <= next_quo;
      neg <= next_neg;
      base <= next_base;
      y_o <= next_y;
      done_o <= next_done;
    end
  end
endmodule : tcf_interp
`default_nettype wire

// ### rtl/tcf_cam.sv
// Purpose: table cam engine, one master axis drives the other axes
// Assumes: encoder counts come from logic on ref_clk_i
// Notes: master and offset steps per cycle stay below one interval
`timescale 1ns/100ps
`default_nettype none
`include "tcf_cfg.svh"
// Contract
// - One master axis drives up to seven slaves from its main encoder.
// - Master source is selectable among all axes' main encoder counts.
// - While running, master position stays wrapped within one master cycle.
// - Master cycle length and per-slave change per cycle are held.
// - At cycle end master position wraps and the table index returns to zero.
// - Master cycle at most 8,388,607; slave change at most 2,147,483,647.
// - Table samples master at uniform spacing, at most 256 intervals.
// - Interval width and master start point are programmable and held.
// - Table index runs 0 to 256, one target per slave each.
// - Enable value 1 switches cam on, 0 switches it off.
// - A slave engages when the master reaches its engage position.
// - Engage position outside one cycle engages the slave at once.
// - On engagement the slave position is wrapped into one slave cycle; the logic adds or subtracts at most one slave cycle per update.
// - A slave disengages when the master reaches its disengage position.
// - Disengage position outside the cycle stops following at once.
// - Host can write the current table index.
// - Host reads enable, index, engage states, cycle sizes and interval.
module tcf_cam #(
  parameter int AXES = `TCF_AXES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic [AXES*`TCF_PW-1:0] enc_i,
  output logic [AXES*`TCF_PW-1:0] slave_pos_o,
  output logic [AXES-1:0] engaged_o
);
  localparam int PW = `TCF_PW;
  localparam int MW = `TCF_MW;
  localparam int IW = `TCF_IW;
  localparam int AW = IW + 3;
  localparam int TDEPTH = (int'(`TCF_LAST_IDX) + 1) * 8;
  if (AXES < 2 || AXES > `TCF_AXES) begin : g_chk
    $error("tcf_cam: AXES out of range");
  end

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b,
                               input int i);
    hit = (a[7:5] == b[7:5]) && (a[4:2] == 3'(i));
  endfunction : hit

  // Crossing test shared by engage and disengage
  function automatic logic reached(input logic [PW-1:0] p,
      input logic [MW-1:0] cyc, input logic [MW-1:0] old,
      input logic [MW-1:0] cur, input logic wrapped);
    logic [MW-1:0] q;
    q = p[MW-1:0];
    if ($signed(p) < 0 || p >= PW'(cyc))
      reached = 1'b1;
    else if (wrapped)
      reached = (q > old) || (q <= cur);
    else
      reached = (q > old && q <= cur) || (q == cur);
  endfunction : reached

  logic cam_en, next_cam_en;
  logic [2:0] msel, next_msel;
  logic [MW-1:0] mcyc, next_mcyc, ivl, next_ivl, start, next_start;
  logic [MW-1:0] mpos, next_mpos;
  logic [IW-1:0] idx, next_idx;
  logic signed [MW:0] off, next_off;
  logic [AW-1:0] tsel, next_tsel;
  logic [PW-1:0] enc_prev, next_enc_prev;
  logic [PW-2:0] scyc [AXES];
  logic [PW-2:0] next_scyc [AXES];
  logic [PW-1:0] engp [AXES];
  logic [PW-1:0] next_engp [AXES];
  logic [PW-1:0] disp [AXES];
  logic [PW-1:0] next_disp [AXES];
  logic [AXES-1:0] eng_arm, next_eng_arm, dis_arm, next_dis_arm;
  logic [AXES-1:0] engaged, next_engaged;
  logic [31:0] rdata, next_rdata;
  logic lock;

  assign lock = |engaged;
  assign engaged_o = engaged;
  assign rdata_o = rdata;

  always_comb begin
    logic signed [PW:0] sum;
    logic signed [PW:0] mc_ext;
    logic [PW-1:0] enc_sel;
    logic [PW-1:0] dlt;
    logic wrapf;
    enc_sel = enc_i[msel*PW +: PW];
    dlt = enc_sel - enc_prev;
    mc_ext = $signed({{(PW+1-MW){1'b0}}, mcyc});
    sum = '0;
    wrapf = 1'b0;
    next_cam_en = cam_en;
    next_msel = msel;
    next_mcyc = mcyc;
    next_ivl = ivl;
    next_start = start;
    next_mpos = mpos;
    next_idx = idx;
    next_off = off;
    next_tsel = tsel;
    next_enc_prev = enc_sel;
    next_scyc = scyc;
    next_engp = engp;
    next_disp = disp;
    next_eng_arm = eng_arm;
    next_dis_arm = dis_arm;
    next_engaged = engaged;
    next_rdata = '0;
    if (cam_en) begin
      sum = $signed({{(PW+1-MW){1'b0}}, mpos}) + $signed({dlt[PW-1], dlt});
      if (sum >= mc_ext) begin
        sum = sum - mc_ext;
        wrapf = 1'b1;
      end else if (sum < 0) begin
        sum = sum + mc_ext;
      end
      next_mpos = sum[MW-1:0];
      if (wrapf) begin
        next_idx = '0;
        next_off = $signed({1'b0, sum[MW-1:0]}) - $signed({1'b0, start});
      end else begin
        next_off = off + $signed(dlt[MW:0]);
      end
      // One step per cycle; steps wider than an interval are unsupported
      if (next_off >= $signed({1'b0, ivl}) && next_idx < `TCF_LAST_IDX) begin
        next_off = next_off - $signed({1'b0, ivl});
        next_idx = next_idx + IW'(1);
      end else if (next_off < 0 && next_idx != '0) begin
        next_off = next_off + $signed({1'b0, ivl});
        next_idx = next_idx - IW'(1);
      end
    end else begin
      next_mpos = '0;
    end
    for (int i = 0; i < AXES; i++) begin
      if (cam_en && eng_arm[i] && !engaged[i] && 3'(i) != msel &&
          reached(engp[i], mcyc, mpos, next_mpos, wrapf)) begin
        next_engaged[i] = 1'b1;
        next_eng_arm[i] = 1'b0;
      end
      if (cam_en && dis_arm[i] && engaged[i] &&
          reached(disp[i], mcyc, mpos, next_mpos, wrapf)) begin
        next_engaged[i] = 1'b0;
        next_dis_arm[i] = 1'b0;
      end
    end
    if (!cam_en)
      next_engaged = '0;
    if (wr_i) begin
      case (addr_i)
        `TCF_A_CTRL: begin
          next_cam_en = wdata_i[`TCF_CTRL_EN];
          if (!lock)
            next_msel = wdata_i[`TCF_SEL_LSB +: 3];
        end
        `TCF_A_MCYC: if (!lock) next_mcyc = wdata_i[MW-1:0];
        `TCF_A_IVL: if (!lock && wdata_i[MW-1:0] != '0)
          next_ivl = wdata_i[MW-1:0];
        `TCF_A_START: if (!lock) next_start = wdata_i[MW-1:0];
        `TCF_A_CNT: begin
          next_idx = (wdata_i[IW-1:0] > `TCF_LAST_IDX || wdata_i[31:IW] != '0)
                     ? `TCF_LAST_IDX : wdata_i[IW-1:0];
          next_off = '0;
        end
        `TCF_A_TSEL: next_tsel = wdata_i[AW-1:0];
        `TCF_A_TDAT: if (!lock) next_tsel = tsel + AW'(1);
        default: begin
        end
      endcase
      for (int i = 0; i < AXES; i++) begin
        if (hit(addr_i, `TCF_A_SCYC, i) && !lock)
          next_scyc[i] = wdata_i[PW-2:0];
        if (hit(addr_i, `TCF_A_ENG, i)) begin
          next_engp[i] = wdata_i;
          next_eng_arm[i] = 1'b1;
        end
        if (hit(addr_i, `TCF_A_DIS, i)) begin
          next_disp[i] = wdata_i;
          next_dis_arm[i] = 1'b1;
        end
      end
    end
    if (rd_i) begin
      case (addr_i)
        `TCF_A_CTRL: next_rdata = {25'h0, msel, 3'h0, cam_en};
        `TCF_A_MCYC: next_rdata = 32'(mcyc);
        `TCF_A_IVL: next_rdata = 32'(ivl);
        `TCF_A_START: next_rdata = 32'(start);
        `TCF_A_CNT: next_rdata = 32'(idx);
        `TCF_A_TSEL: next_rdata = 32'(tsel);
        `TCF_A_STAT: begin
          next_rdata[AXES-1:0] = engaged;
          next_rdata[`TCF_STAT_DIS_LSB +: AXES] = dis_arm;
        end
        `TCF_A_MPOS: next_rdata = 32'(mpos);
        default: begin
        end
      endcase
      for (int i = 0; i < AXES; i++) begin
        if (hit(addr_i, `TCF_A_SCYC, i)) next_rdata = 32'(scyc[i]);
        if (hit(addr_i, `TCF_A_ENG, i)) next_rdata = engp[i];
        if (hit(addr_i, `TCF_A_DIS, i)) next_rdata = disp[i];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cam_en <= 1'b0;
      msel <= '0;
      mcyc <= '0;
      ivl <= `TCF_RST_IVL;
      start <= '0;
      mpos <= '0;
      idx <= '0;
      off <= '0;
      tsel <= '0;
      enc_prev <= '0;
      scyc <= '{default: '0};
      engp <= '{default: '0};
      disp <= '{default: '0};
      eng_arm <= '0;
      dis_arm <= '0;
      engaged <= '0;
      rdata <= '0;
    end else if (ce_i) begin
      cam_en <= next_cam_en;
      msel <= next_msel;
      mcyc <= next_mcyc;
      ivl <= next_ivl;
      start <= next_start;
      mpos <= next_mpos;
      idx <= next_idx;
      off <= next_off;
      tsel <= next_tsel;
      enc_prev <= next_enc_prev;
      scyc <= next_scyc;
      engp <= next_engp;
      disp <= next_disp;
      eng_arm <= next_eng_arm;
      dis_arm <= next_dis_arm;
      engaged <= next_engaged;
      rdata <= next_rdata;
    end
  end

  // Table memory, address {index, axis}; no reset, software loads it
  logic [PW-1:0] tbl [TDEPTH];
  logic [PW-1:0] tbl_q;
  logic [AW-1:0] raddr;
  logic tbl_we;
  assign tbl_we = wr_i && addr_i == `TCF_A_TDAT && !lock &&
                  int'(tsel) < TDEPTH;
  always_ff @(posedge ref_clk_i) begin
    if (ce_i) begin
      if (tbl_we)
        tbl[tsel] <= wdata_i;
      tbl_q <= tbl[raddr];
    end
  end

  // Sequencer: one axis at a time through the interpolator
  tcf_pkg::tcf_seq_t seq, next_seq;
  logic [2:0] ax, next_ax;
  logic [IW-1:0] sidx, next_sidx;
  logic [MW-1:0] soff, next_soff;
  logic [PW-1:0] ta, next_ta;
  logic [PW-1:0] spos [AXES];
  logic [PW-1:0] next_spos [AXES];
  logic istart, idone;
  logic [PW-1:0] iy;

  always_comb begin
    logic [PW-1:0] c;
    c = {1'b0, scyc[ax]};
    next_seq = seq;
    next_ax = ax;
    next_sidx = sidx;
    next_soff = soff;
    next_ta = ta;
    next_spos = spos;
    istart = 1'b0;
    raddr = {sidx, ax};
    case (seq)
      tcf_pkg::SQ_IDLE: begin
        if (cam_en) begin
          next_ax = '0;
          next_sidx = idx;
          next_soff = off < 0 ? '0 : off[MW-1:0];
          next_seq = tcf_pkg::SQ_RDA;
        end
      end
      tcf_pkg::SQ_RDA: next_seq = tcf_pkg::SQ_RDB;
      tcf_pkg::SQ_RDB: begin
        next_ta = tbl_q;
        raddr = {(sidx == `TCF_LAST_IDX) ? sidx : sidx + IW'(1), ax};
        next_seq = tcf_pkg::SQ_ST;
      end
      tcf_pkg::SQ_ST: begin
        istart = 1'b1;
        next_seq = tcf_pkg::SQ_RUN;
      end
      tcf_pkg::SQ_RUN: begin
        if (idone) begin
          if (engaged[ax]) begin
            next_spos[ax] = iy;
            // Single correction keeps table values near one slave cycle
            if (c != '0 && $signed(iy) >= $signed(c))
              next_spos[ax] = iy - c;
            else if (c != '0 && $signed(iy) < 0)
              next_spos[ax] = iy + c;
          end
          next_ax = ax + 3'h1;
          next_seq = (int'(ax) == AXES - 1) ? tcf_pkg::SQ_IDLE
                                            : tcf_pkg::SQ_RDA;
        end
      end
      default: next_seq = tcf_pkg::SQ_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq <= tcf_pkg::SQ_IDLE;
      ax <= '0;
      sidx <= '0;
      soff <= '0;
      ta <= '0;
      spos <= '{default: '0};
    end else if (ce_i) begin
      seq <= next_seq;
      ax <= next_ax;
      sidx <= next_sidx;
      soff <= next_soff;
      ta <= next_ta;
      spos <= next_spos;
    end
  end

  for (genvar g = 0; g < AXES; g++) begin : g_out
    assign slave_pos_o[g*PW +: PW] = spos[g];
  end

  tcf_interp #(.PW(PW), .MW(MW)) u_interp (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .start_i(istart),
    .a_i(ta),
    .b_i(tbl_q),
    .off_i(soff),
    .ivl_i(ivl),
    .done_o(idone),
    .y_o(iy)
  );

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence s_far_eng;
    wr_i && addr_i == (`TCF_A_ENG + 8'h04) && wdata_i[PW-1] && cam_en &&
    msel != 3'h1 && !engaged[1];
  endsequence
  sequence s_far_dis;
    wr_i && addr_i == (`TCF_A_DIS + 8'h04) && wdata_i[PW-1] && engaged[1];
  endsequence

  AST_MPOS_WRAP: assert property (cam_en && mpos < mcyc &&
    !(wr_i && addr_i == `TCF_A_MCYC) |=> mpos < mcyc)
    else $error("master position left its cycle");
  AST_IDX_MAX: assert property (idx <= `TCF_LAST_IDX)
    else $error("table index beyond last entry");
  AST_OFF_CLEARS: assert property (!cam_en |=> engaged == '0)
    else $error("axis engaged while cam disabled");
  AST_NO_SELF: assert property ($stable(msel) |-> !engaged[msel])
    else $error("master axis engaged as slave");
  AST_LOCK_MCYC: assert property (lock && wr_i &&
    addr_i == `TCF_A_MCYC |=> $stable(mcyc))
    else $error("cycle length changed while engaged");
  AST_IMM_ENG: assert property (s_far_eng ##1 (cam_en && !dis_arm[1] &&
    msel != 3'h1) |=> engaged[1])
    else $error("out of range engage did not engage");
  AST_IMM_DIS: assert property (s_far_dis ##1 cam_en |=> !engaged[1])
    else $error("out of range disengage did not stop");
  AST_CNT_SET: assert property (wr_i && addr_i == `TCF_A_CNT &&
    wdata_i < 32'(`TCF_LAST_IDX) |=> idx == $past(wdata_i[IW-1:0]))
    else $error("table counter write lost");
  AST_RD_EN: assert property (rd_i && addr_i == `TCF_A_CTRL |=>
    rdata_o[`TCF_CTRL_EN] == $past(cam_en))
    else $error("enable readback wrong");
endmodule : tcf_cam
`default_nettype wire

// ### bench/tcf_enc_model.sv
// Purpose: encoder counts of all axes as the cam engine sees them
// Assumes: one axis moves at a time, bench picks it and its step
// Notes: counts hold when not moving, like a stopped shaft
`timescale 1ns/100ps
`default_nettype none
module tcf_enc_model #(
  parameter int AXES = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [2:0] axis_i,
  input wire logic [31:0] step_i,
  output logic [AXES*32-1:0] enc_o
);
  logic [AXES*32-1:0] next_enc;

  always_comb begin
    next_enc = enc_o;
    if (run_i) begin
      // Steps stay below one interval per clock
      next_enc[{axis_i, 5'h00}+:32] = enc_o[{axis_i, 5'h00}+:32] + step_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      enc_o <= '0;
    end else begin
      enc_o <= next_enc;
    end
  end
endmodule : tcf_enc_model
`default_nettype wire

// ### bench/table_based_cam_follower_tb.sv
// Purpose: register-level test of the table cam engine
// Assumes: axis 2 is master, slave positions checked on axis 1
// Notes: engage timing judged from encoder counts, not design state
`timescale 1ns/100ps
`default_nettype none
`include "tcf_cfg.svh"
module table_based_cam_follower_tb;
  localparam int AXES = 8;
  logic ref_clk_i;
  logic rst_i;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic wr_i;
  logic rd_i;
  logic enc_run;
  logic [31:0] enc_step;
  logic [31:0] rdata_o;
  logic [AXES*32-1:0] enc_i;
  logic [AXES*32-1:0] slave_pos_o;
  logic [AXES-1:0] engaged_o;
  int n_fail;
  int checks_done;

  tcf_enc_model #(.AXES(AXES)) u_enc (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .run_i(enc_run),
    .axis_i(3'h2), .step_i(enc_step), .enc_o(enc_i)
  );

  tcf_cam #(.AXES(AXES)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(1'b1), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .enc_i(enc_i), .slave_pos_o(slave_pos_o), .engaged_o(engaged_o)
  );

  task automatic final_report();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flags(input logic [AXES-1:0] got,
                           input logic [AXES-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_flags

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    chk_word(rdata_o, exp);
  endtask : rd_chk

  task automatic run_master(input logic [31:0] s, input int n);
    @(posedge ref_clk_i);
    enc_step <= s;
    enc_run <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    enc_run <= 1'b0;
    repeat (2) @(posedge ref_clk_i);
  endtask : run_master

  task automatic wait_eng(input int ax, input logic v, input int bound);
    for (int i = 0; i < bound && engaged_o[ax] !== v; i++) begin
      @(posedge ref_clk_i);
      #1;
    end
  endtask : wait_eng

  // Master seen by the design lags the encoder by a step or two
  task automatic chk_near(input logic [31:0] t);
    logic [31:0] p;
    p = enc_i[64+:32] % 32'h000003E8;
    chk_word({31'h0, p >= t && p <= t + 32'h14}, 32'h1);
  endtask : chk_near

  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    final_report();
  end

  initial begin
    rst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    enc_run = 1'b0;
    enc_step = 32'h0;
    n_fail = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rd_chk(`TCF_A_CTRL, 32'h0);
    rd_chk(`TCF_A_MCYC, 32'h0);
    rd_chk(`TCF_A_IVL, 32'(`TCF_RST_IVL));
    rd_chk(`TCF_A_CNT, 32'h0);
    rd_chk(`TCF_A_STAT, 32'h0);
    rd_chk(8'hFC, 32'h0);
    chk_flags(engaged_o, 8'h00);
    wr(`TCF_A_MCYC, 32'h007FFFFF);
    rd_chk(`TCF_A_MCYC, 32'h007FFFFF);
    wr(`TCF_A_MCYC, 32'h000003E8);
    rd_chk(`TCF_A_MCYC, 32'h000003E8);
    wr(`TCF_A_IVL, 32'h00000064);
    wr(`TCF_A_IVL, 32'h0);
    rd_chk(`TCF_A_IVL, 32'h00000064);
    wr(`TCF_A_START, 32'h0);
    rd_chk(`TCF_A_START, 32'h0);
    // Magnitude only, even for a falling slave
    wr(`TCF_A_SCYC + 8'h04, 32'h000003E8);
    rd_chk(`TCF_A_SCYC + 8'h04, 32'h000003E8);
    // Axis 1 at index 5 and 6, above one slave cycle so the wrap acts
    wr(`TCF_A_TSEL, 32'h00000029);
    wr(`TCF_A_TDAT, 32'h000004B0);
    wr(`TCF_A_TSEL, 32'h00000031);
    wr(`TCF_A_TDAT, 32'h00000514);
    wr(`TCF_A_CNT, 32'h0000012C);
    rd_chk(`TCF_A_CNT, 32'h00000100);
    wr(`TCF_A_CNT, 32'h0);
    wr(`TCF_A_CTRL, 32'h00000021);
    rd_chk(`TCF_A_CTRL, 32'h00000021);
    run_master(32'h5, 110);
    rd_chk(`TCF_A_MPOS, 32'h00000226);
    rd_chk(`TCF_A_CNT, 32'h00000005);
    // Master axis itself must never engage
    wr(`TCF_A_ENG + 8'h08, 32'hFFFFFFFF);
    wr(`TCF_A_ENG + 8'h04, 32'hFFFFFFFF);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk_flags(engaged_o, 8'h02);
    rd_chk(`TCF_A_STAT, 32'h00000002);
    wr(`TCF_A_MCYC, 32'h000007D0);
    rd_chk(`TCF_A_MCYC, 32'h000003E8);
    repeat (700) @(posedge ref_clk_i);
    #1;
    chk_word(slave_pos_o[32+:32], 32'h000000FA);
    wr(`TCF_A_DIS + 8'h04, 32'hFFFFFFFF);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk_flags(engaged_o, 8'h00);
    wr(`TCF_A_ENG + 8'h0C, 32'h00000320);
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk_flags(engaged_o, 8'h00);
    fork
      run_master(32'h5, 150);
      begin
        wait_eng(3, 1'b1, 200);
        chk_near(32'h00000320);
      end
    join
    #1;
    chk_flags(engaged_o, 8'h08);
    rd_chk(`TCF_A_MPOS, enc_i[64+:32] % 32'h000003E8);
    wr(`TCF_A_DIS + 8'h0C, 32'h00000064);
    rd_chk(`TCF_A_STAT, 32'h00000808);
    fork
      run_master(32'h5, 200);
      begin
        wait_eng(3, 1'b0, 250);
        chk_near(32'h00000064);
      end
    join
    #1;
    chk_flags(engaged_o, 8'h00);
    rd_chk(`TCF_A_MPOS, enc_i[64+:32] % 32'h000003E8);
    wr(`TCF_A_CTRL, 32'h00000020);
    rd_chk(`TCF_A_CTRL, 32'h00000020);
    rd_chk(`TCF_A_MPOS, 32'h0);
    final_report();
  end
endmodule : table_based_cam_follower_tb
`default_nettype wire
